// File: cell_cluster.sv
// cluster of ten logic cells with an AHB-Lite configuration and status port
//
// How it works
// R1: cascade joins neighbouring table outputs by AND, or OR via double inversion.
// R2: each cell added to a cascade adds four inputs to the function.
// R3: beyond ten cells a cascade continues to the next same-parity cluster.
// R4: each cell runs in normal, arithmetic or counter mode.
// R5: each cell has four data inputs, register feedback, carry-in and cascade-in.
// R6: register controls come from cluster-wide signals in every mode.
// R7: a cluster has exactly two shared clock enables.
// R8: normal mode may pack the register, but not when carry-in feeds the table.
// R9: register feedback multiplexer exists only on the first cell.
// R10: data inputs one and two carry count controls except on the second cell.
// R11: normal mode uses a four-input table; one input is carry-in or data three.
// R12: normal mode combines table output with cascade-in into cascade-out.
// R13: arithmetic mode uses two three-input tables for result and carry-out.
// R14: arithmetic mode allows cascade and drives registered and plain outputs.
// R15: counter enable and direction come from data inputs.
// R16: synchronous clear and load are cluster-wide and hit every register.
// R17: counter uses two tables, a load multiplexer and a clear AND gate.
// R18: synchronous clear or load beats the cascade; clear beats load.
// R19: the register natively has only an asynchronous clear.
// R20: the enabled chip-wide reset resets every register over all other controls.
// R21: preset-emulating registers go to preset on chip-wide reset.
// R22: registers emulating preset and load are unknown after chip-wide reset.
// R23: a cluster holds ten cells chained in order by carry and cascade.
// R24: two cluster clocks, each tied to its own enable.
// R25: the register updates on its clock tick only while its enable is high.
// R26: modes and table contents are static while the cluster runs.
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module cell_cluster (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [39:0] data_pins,
  input wire cell_cluster_pkg::cluster_ctl_type ctl_pins,
  input wire logic carry_in_pin,
  input wire logic cascade_in_pin,
  input wire logic chip_wide_reset_n,
  output logic [9:0] lut_out,
  output logic [9:0] reg_out,
  output logic carry_out,
  output logic cascade_to_next_same_parity
);

  localparam int CELLS = cell_cluster_pkg::CELLS;
  localparam int SYNC_W = 40 + $bits(cell_cluster_pkg::cluster_ctl_type) + 3;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the first stage feeds only the second

  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;
  logic [39:0] data_s;
  cell_cluster_pkg::cluster_ctl_type ctl_s;
  logic carry_in_s;
  logic cascade_in_s;
  logic chip_reset_n_s;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= {{(SYNC_W-1){1'b0}}, 1'b1};
      pin_sync <= {{(SYNC_W-1){1'b0}}, 1'b1};
    end
    else
    begin
      pin_meta <= {data_pins, ctl_pins, carry_in_pin, cascade_in_pin, chip_wide_reset_n};
      pin_sync <= pin_meta;
    end
  end

  assign {data_s, ctl_s, carry_in_s, cascade_in_s, chip_reset_n_s} = pin_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration state

  logic run;
  logic chip_reset_enable;
  cell_cluster_pkg::cell_cfg_type cfg [CELLS];
  logic refused;
  logic chip_rst;

  // the reset pin only acts when the option was set before running
  assign chip_rst = chip_reset_enable && !chip_reset_n_s; // R20

  ////////////////////////////////////////////////////////////////////////////////
  // the ten cells, chained in order

  logic [CELLS:0] carry_link;
  logic [CELLS:0] casc_link;
  logic [CELLS-1:0] cell_lut;
  logic [CELLS-1:0] cell_q;
  logic [CELLS-1:0] cell_unknown;

  assign carry_link[0] = carry_in_s;
  assign casc_link[0] = cascade_in_s;

  genvar gi;
  generate
    for (gi = 0; gi < CELLS; gi++)
    begin : g_cell
      logic_cell #(
        .FIRST(gi == 0),
        .SECOND(gi == 1)
      ) u_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(cfg[gi]),
        .data(data_s[gi*4 +: 4]),
        .carry_in(carry_link[gi]), // R23
        .cascade_in(casc_link[gi]), // R23
        .ctl(ctl_s), // R6 R7 R16
        .chip_rst(chip_rst),
        .lut_out(cell_lut[gi]),
        .carry_out(carry_link[gi+1]),
        .cascade_out(casc_link[gi+1]),
        .q(cell_q[gi]),
        .unknown(cell_unknown[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lut_out <= 10'h000;
      reg_out <= 10'h000;
      carry_out <= 1'b0;
      cascade_to_next_same_parity <= 1'b0;
    end
    else
    begin
      lut_out <= cell_lut; // R14
      reg_out <= cell_q; // R14
      carry_out <= carry_link[CELLS];
      // the last cell feeds the first cell two clusters on, keeping parity
      cascade_to_next_same_parity <= casc_link[CELLS]; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // derived status

  logic [7:0] fanin;
  logic conflict;
  logic [CELLS-1:0] illegal_mode;

  // fan-in of the cascade that starts at the first cell
  always_comb
  begin
    logic open_chain;
    open_chain = 1'b1;
    fanin = 8'h04;
    for (int i = 1; i < CELLS; i++)
    begin
      open_chain = open_chain && cfg[i].casc_use;
      if (open_chain)
        fanin = fanin + 8'h04; // R2
    end
  end

  // a counter shares sync clear and load with every register in the cluster
  always_comb
  begin
    logic any_counter;
    logic any_other_reg;
    any_counter = 1'b0;
    any_other_reg = 1'b0;
    for (int i = 0; i < CELLS; i++)
    begin
      if (cfg[i].mode == 2'(cell_cluster_pkg::mode_counter))
        any_counter = 1'b1;
      else if (cfg[i].packed_reg || cfg[i].preset_emul)
        any_other_reg = 1'b1;
    end
    conflict = any_counter && any_other_reg; // R16
  end

  generate
    for (gi = 0; gi < CELLS; gi++)
    begin : g_illegal
      assign illegal_mode[gi] = (cfg[gi].mode == 2'h3); // R4
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes have no wait state, reads take one

  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_pend;
  logic [7:0] rd_addr;
  logic take;
  logic wr_cell;
  logic [3:0] wr_index;

  assign take = hsel && hready && (htrans == cell_cluster_pkg::HTRANS_NONSEQ);
  assign wr_cell = (wr_addr >= cell_cluster_pkg::CELL_BASE) && (wr_addr <= cell_cluster_pkg::CELL_LAST);
  assign wr_index = 4'((wr_addr - cell_cluster_pkg::CELL_BASE) >> 2);

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    logic [7:0] idx;
    w = 32'h0000_0000;
    idx = (a - cell_cluster_pkg::CELL_BASE) >> 2;
    unique case (a)
      cell_cluster_pkg::CTRL_OFFSET:
        w = {30'h0, chip_reset_enable, run};
      cell_cluster_pkg::STATUS_OFFSET:
        w = {12'h000, cell_unknown, cell_q};
      cell_cluster_pkg::OUTS_OFFSET:
        w = {cascade_to_next_same_parity, carry_out, 10'h000, lut_out, reg_out};
      cell_cluster_pkg::PINS_OFFSET:
        w = data_s[31:0];
      cell_cluster_pkg::INFO_OFFSET:
        w = {6'h0, illegal_mode, 7'h0, conflict, fanin};
      cell_cluster_pkg::ERR_OFFSET:
        w = {31'h0, refused};
      default:
      begin
        if (a >= cell_cluster_pkg::CELL_BASE && a <= cell_cluster_pkg::CELL_LAST && a[1:0] == 2'h0)
          w = cfg[idx[3:0]] & cell_cluster_pkg::CELL_CFG_MASK;
      end
    endcase
    return w;
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (take && hwrite && hsize == 3'h2)
    begin
      wr_pend <= 1'b1;
      wr_addr <= haddr[7:0];
    end
    else
      wr_pend <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_pend <= 1'b0;
      rd_addr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend)
    begin
      // sampled a cycle late so a write just before is already visible
      rd_pend <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= read_word(rd_addr);
    end
    else if (take && !hwrite)
    begin
      rd_pend <= 1'b1;
      rd_addr <= haddr[7:0];
      hreadyout <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes; configuration is frozen while running

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run <= cell_cluster_pkg::CTRL_RESET[cell_cluster_pkg::CTRL_RUN_BIT];
      chip_reset_enable <= cell_cluster_pkg::CTRL_RESET[cell_cluster_pkg::CTRL_CHIP_RESET_ENABLE_BIT];
    end
    else if (wr_pend && wr_addr == cell_cluster_pkg::CTRL_OFFSET)
    begin
      run <= hwdata[cell_cluster_pkg::CTRL_RUN_BIT];
      if (!run)
        chip_reset_enable <= hwdata[cell_cluster_pkg::CTRL_CHIP_RESET_ENABLE_BIT]; // R20 R26
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < CELLS; i++)
        cfg[i] <= cell_cluster_pkg::CELL_CFG_RESET;
    end
    else if (wr_pend && wr_cell && !run && wr_addr[1:0] == 2'h0)
      cfg[wr_index] <= hwdata & cell_cluster_pkg::CELL_CFG_MASK; // R26
  end

  // refused configuration writes: a new refusal wins over a clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      refused <= 1'b0;
    else if (wr_pend && run && (wr_cell || wr_addr == cell_cluster_pkg::CTRL_OFFSET))
    begin
      if (wr_cell || hwdata[cell_cluster_pkg::CTRL_CHIP_RESET_ENABLE_BIT] != chip_reset_enable)
        refused <= 1'b1; // R26
    end
    else if (wr_pend && wr_addr == cell_cluster_pkg::ERR_OFFSET && hwdata[0])
      refused <= 1'b0;
  end

endmodule

// File: cell_cluster_asserts.sv
// port checker for the cell cluster
`timescale 1ns/1ps
module cell_cluster_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [39:0] data_pins,
  input wire cell_cluster_pkg::cluster_ctl_type ctl_pins,
  input wire logic carry_in_pin,
  input wire logic cascade_in_pin,
  input wire logic chip_wide_reset_n,
  input wire logic [9:0] lut_out,
  input wire logic [9:0] reg_out
);
  logic take, rd_take, wr_take, act;
  logic [3:0] reg_quiet, lut_quiet;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign take = hsel && hready && htrans == cell_cluster_pkg::HTRANS_NONSEQ;
  assign rd_take = take && !hwrite;
  assign wr_take = take && hwrite;
  assign act = |(ctl_pins.clk_tick & ctl_pins.clk_ena) || |ctl_pins.async_clr || !chip_wide_reset_n || wr_take;
  ////////////////////////////////////////////////////////////////////////
  // cycles since anything that may move a register; margin covers the pin sync
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reg_quiet <= 4'h0;
    else if (act || $changed(ctl_pins))
      reg_quiet <= 4'h0;
    else if (reg_quiet != 4'hF)
      reg_quiet <= reg_quiet + 4'h1;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lut_quiet <= 4'h0;
    else if (act || $changed(ctl_pins) || $changed(data_pins) || $changed({carry_in_pin, cascade_in_pin, reg_out}))
      lut_quiet <= 4'h0;
    else if (lut_quiet != 4'hF)
      lut_quiet <= lut_quiet + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write inserted a wait state");
  chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  chk_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without a read");
  chk_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside a read completion");
  chk_reg_quiet: assert property ($changed(reg_out) |-> reg_quiet < 4'h8)
    else $error("cell register moved without an enabled tick");
  chk_lut_quiet: assert property ($changed(lut_out) |-> lut_quiet < 4'h8)
    else $error("table output moved without an input change");
  chk_sync_clear: assert property ((ctl_pins.sync_clr && &(ctl_pins.clk_tick & ctl_pins.clk_ena) &&
    ctl_pins.async_clr == 2'h0 && chip_wide_reset_n) [*6] |-> reg_out == 10'h000)
    else $error("synchronous clear left a register set");
  cov_read: cover property (rd_take ##2 hreadyout);
  cov_tick: cover property (|(ctl_pins.clk_tick & ctl_pins.clk_ena));
  cov_chip: cover property (!chip_wide_reset_n [*4]);
endmodule
bind cell_cluster cell_cluster_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .data_pins(data_pins),
  .ctl_pins(ctl_pins), .carry_in_pin(carry_in_pin), .cascade_in_pin(cascade_in_pin),
  .chip_wide_reset_n(chip_wide_reset_n), .lut_out(lut_out), .reg_out(reg_out));

// File: cell_cluster_pkg.sv
// shared constants and types for the logic cell cluster
package cell_cluster_pkg;

  localparam int CELLS = 10;
  localparam int DATA_INPUTS = 4;
  localparam int LUT_BITS = 16;
  localparam int CLOCKS = 2;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] OUTS_OFFSET = 8'h08;
  localparam logic [7:0] PINS_OFFSET = 8'h0C;
  localparam logic [7:0] INFO_OFFSET = 8'h10;
  localparam logic [7:0] ERR_OFFSET = 8'h14;
  localparam logic [7:0] CELL_BASE = 8'h40;
  localparam logic [7:0] CELL_LAST = 8'h64;

  // control word fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CHIP_RESET_ENABLE_BIT = 1;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // info word fields
  localparam int INFO_FANIN_LSB = 0;
  localparam int INFO_CONFLICT_BIT = 8;
  localparam int INFO_ILLEGAL_LSB = 16;

  // per cell configuration word, reserved bits read as zero
  localparam logic [31:0] CELL_CFG_MASK = 32'h03FF_FFFF;
  localparam logic [31:0] CELL_CFG_RESET = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    mode_normal,
    mode_arithmetic,
    mode_counter
  } mode_type;

  typedef struct packed {
    logic [5:0] reserved;
    logic fb_sel;
    logic preset_load_emul;
    logic preset_emul;
    logic packed_reg;
    logic casc_or;
    logic casc_use;
    logic carry_to_lut;
    logic clk_sel;
    logic [1:0] mode;
    logic [LUT_BITS-1:0] lut;
  } cell_cfg_type;

  typedef struct packed {
    logic [CLOCKS-1:0] clk_tick;
    logic [CLOCKS-1:0] clk_ena;
    logic [CLOCKS-1:0] async_clr;
    logic sync_clr;
    logic sync_load;
  } cluster_ctl_type;

endpackage

// File: cell_cluster_tb.sv
// self-checking testbench for the cell cluster
`timescale 1ns/1ps
module cell_cluster_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, carry_in_pin, cascade_in_pin, chip_wide_reset_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, tick_req, ena, aclr;
  logic [2:0] hsize;
  logic [39:0] data_pins;
  logic [9:0] lut_out, reg_out;
  logic slow, sclr, sload;
  logic carry_out, casc_out;
  cell_cluster_pkg::cluster_ctl_type ctl_pins;
  int n_fail, cmp_count, cyc;
  cell_cluster dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .data_pins(data_pins), .ctl_pins(ctl_pins), .carry_in_pin(carry_in_pin), .cascade_in_pin(cascade_in_pin),
    .chip_wide_reset_n(chip_wide_reset_n), .lut_out(lut_out), .reg_out(reg_out), .carry_out(carry_out),
    .cascade_to_next_same_parity(casc_out));
  cluster_ctl_model ctl_u (.hclk(hclk), .hresetn(hresetn), .tick_req(tick_req), .slow(slow), .ena(ena), .aclr(aclr),
    .sclr(sclr), .sload(sload), .ctl_pins(ctl_pins));
  ////////////////////////////////////////////////////////////////////////
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single word transfer; waits on hready only, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= cell_cluster_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [1:0] w);
    tick_req <= w;
    @(posedge hclk);
    tick_req <= 2'h0;
    wait_cyc(8);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk(8'h00, 32'h0);
    rchk(8'h40, 32'h0);
    wr(8'h80, 32'hFFFF_FFFF);
    rchk(8'h80, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h03FF_FFFF);
  endtask
  task automatic t_lut;
    wr(8'h40, 32'h0000_8000);
    wr(8'h44, 32'h0010_0000);
    wr(8'h48, 32'h0010_0000);
    wr(8'h4C, 32'h0003_0000);
    data_pins[3:0] <= 4'hF;
    wait_cyc(6);
    chk({22'h0, lut_out}, 32'h1);
    data_pins[3:0] <= 4'hE;
    wait_cyc(6);
    chk({22'h0, lut_out}, 32'h0);
    rchk(8'h10, 32'h0008_000C);
    // table input three taken from carry while data three stays low
    wr(8'h40, 32'h0008_8000);
    data_pins[3:0] <= 4'hB;
    carry_in_pin <= 1'b1;
    wait_cyc(6);
    chk({22'h0, lut_out}, 32'h1);
    carry_in_pin <= 1'b0;
    wait_cyc(6);
    chk({22'h0, lut_out}, 32'h0);
    // last cell in arithmetic mode: table halves on result and carry, cascade and versus or
    wr(8'h64, 32'h0011_FFFF);
    wait_cyc(3);
    chk({29'h0, lut_out[9], carry_out, casc_out}, 32'h6);
    wr(8'h64, 32'h0031_00FF);
    wait_cyc(3);
    chk({29'h0, lut_out[9], carry_out, casc_out}, 32'h5);
    rchk(8'h08, 32'h8008_0000);
    wr(8'h64, 32'h0);
    wr(8'h44, 32'h0);
    wr(8'h48, 32'h0);
    wr(8'h4C, 32'h0);
  endtask
  task automatic t_counter;
    wr(8'h40, 32'h0002_0055);
    // the second cell counts with enable and direction forced, whatever its data pins say
    wr(8'h44, 32'h0002_0055);
    wr(8'h00, 32'h1);
    data_pins[3:0] <= 4'h1;
    ena <= 2'h1;
    pulse(2'h1);
    chk({22'h0, reg_out}, 32'h3);
    ena <= 2'h0;
    pulse(2'h1);
    chk({22'h0, reg_out}, 32'h3);
    ena <= 2'h1;
    slow <= 1'b1;
    pulse(2'h1);
    chk({22'h0, reg_out}, 32'h0);
    slow <= 1'b0;
    pulse(2'h1);
    data_pins[3:0] <= 4'h5;
    {sclr, sload, ena, tick_req} <= 6'h3F;
    wait_cyc(8);
    tick_req <= 2'h0;
    wait_cyc(6);
    chk({22'h0, reg_out}, 32'h0);
    sclr <= 1'b0;
    pulse(2'h1);
    chk({22'h0, reg_out}, 32'h1);
    sload <= 1'b0;
    aclr <= 2'h1;
    wait_cyc(6);
    chk({22'h0, reg_out}, 32'h0);
    aclr <= 2'h0;
  endtask
  task automatic t_chip;
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h0100_0000);
    wr(8'h48, 32'h0080_0000);
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h3);
    chip_wide_reset_n <= 1'b0;
    wait_cyc(6);
    chk({22'h0, reg_out & 10'h3FD}, 32'h4);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h0000_0C05, 32'h0000_0804);
    chip_wide_reset_n <= 1'b1;
    wr(8'h00, 32'h1);
    rchk(8'h00, 32'h3);
    wr(8'h44, 32'h0000_FFFF);
    rchk(8'h44, 32'h0100_0000);
    rchk(8'h14, 32'h1);
    wr(8'h14, 32'h1);
    rchk(8'h14, 32'h0);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      end_sim;
    end
  end
  initial
  begin
    {hresetn, hsel, hwrite, carry_in_pin, cascade_in_pin, slow, sclr, sload} = 8'h00;
    {haddr, hwdata, htrans, tick_req, ena, aclr, hsize, data_pins} = '0;
    chip_wide_reset_n = 1'b1;
    {n_fail, cmp_count, cyc} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_lut;
    t_counter;
    t_chip;
    end_sim;
  end
endmodule

// File: cluster_ctl_model.sv
// model of the neighbouring cluster control logic that drives the cluster pins
`timescale 1ns/1ps
module cluster_ctl_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] tick_req,
  input wire logic slow,
  input wire logic [1:0] ena,
  input wire logic [1:0] aclr,
  input wire logic sclr,
  input wire logic sload,
  output cell_cluster_pkg::cluster_ctl_type ctl_pins
);
  logic [1:0] late1, late2;
  ////////////////////////////////////////////////////////////////////////
  // a slow neighbour delivers its tick two cycles late
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {late1, late2} <= 4'h0;
    else
      {late1, late2} <= {tick_req, late1};
  end
  // each clock tick travels with its own enable, except a slow tick, which arrives two cycles after it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctl_pins <= '0;
    else
      ctl_pins <= {slow ? late2 : tick_req, ena, aclr, sclr, sload};
  end
endmodule

// File: logic_cell.sv
// one logic cell: lookup table, chain links and its register
`timescale 1ns/1ps
module logic_cell #(
  parameter bit FIRST = 1'b0,
  parameter bit SECOND = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire cell_cluster_pkg::cell_cfg_type cfg,
  input wire logic [3:0] data,
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire cell_cluster_pkg::cluster_ctl_type ctl,
  input wire logic chip_rst,
  output logic lut_out,
  output logic carry_out,
  output logic cascade_out,
  output logic q,
  output logic unknown
);

  cell_cluster_pkg::mode_type mode;
  logic first_in;
  logic count_en;
  logic count_up;
  logic in3;
  logic chain;
  logic d;
  logic sel;

  assign mode = cell_cluster_pkg::mode_type'(cfg.mode);
  assign sel = cfg.clk_sel;

  always_comb
  begin
    // feedback steering exists on the first cell only
    first_in = (FIRST && cfg.fb_sel) ? q : data[0]; // R9
    // second cell cannot take count controls from its data inputs
    count_en = SECOND ? 1'b1 : first_in; // R10
    count_up = SECOND ? 1'b1 : data[1]; // R15
    in3 = cfg.carry_to_lut ? carry_in : data[2]; // R11
    lut_out = 1'b0;
    carry_out = 1'b0;
    unique case (mode) // R4 R5
      cell_cluster_pkg::mode_normal:
      begin
        lut_out = cfg.lut[{data[3], in3, data[1], first_in}]; // R11
      end
      cell_cluster_pkg::mode_arithmetic:
      begin
        lut_out = cfg.lut[{1'b0, carry_in, data[1], first_in}]; // R13
        carry_out = cfg.lut[{1'b1, carry_in, data[1], first_in}]; // R13
      end
      cell_cluster_pkg::mode_counter:
      begin
        lut_out = cfg.lut[{1'b0, carry_in, count_up, q}]; // R17
        carry_out = cfg.lut[{1'b1, carry_in, count_up, q}]; // R17
      end
      default:
      begin
        lut_out = 1'b0;
        carry_out = 1'b0;
      end
    endcase
    // or is built from the and gate by inverting both sides
    if (!cfg.casc_use)
      chain = lut_out;
    else if (cfg.casc_or)
      chain = ~(~lut_out & ~cascade_in); // R1
    else
      chain = lut_out & cascade_in; // R1 R12 R14
    cascade_out = chain; // R2
    if (mode == cell_cluster_pkg::mode_normal && cfg.packed_reg && !cfg.carry_to_lut)
      d = data[3]; // R8
    else if (mode == cell_cluster_pkg::mode_counter)
      d = count_en ? chain : q; // R15
    else
      d = chain;
    // load mux then clear gate, so clear beats load and both beat the chain
    d = ctl.sync_load ? data[2] : d; // R16 R17 R18
    d = d & ~ctl.sync_clr; // R17 R18
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register: only async clear is native; preset emulation makes async clear and chip reset load a one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= 1'b0;
    else if (chip_rst)
      q <= cfg.preset_emul; // R20 R21
    else if (ctl.async_clr[sel])
      q <= cfg.preset_emul; // R6 R19
    else if (ctl.clk_tick[sel] && ctl.clk_ena[sel])
      q <= d; // R24 R25
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      unknown <= 1'b0;
    else if (chip_rst)
      unknown <= cfg.preset_load_emul; // R22
    else if (ctl.clk_tick[sel] && ctl.clk_ena[sel] && (ctl.sync_load || ctl.sync_clr))
      unknown <= 1'b0;
  end

endmodule
